// ### inc/fsps_pkg.sv
// Constants, types and register map for the flash self-programming sequencer.
// Assumes a single 125 MHz system clock and an AHB-Lite register port.
package fsps_pkg;
  // ****************************************
  // Geometry and pointer fields
  // ****************************************
  localparam int FSPS_WORD_W = 5;
  localparam int FSPS_PAGE_W = 10;
  localparam int FSPS_PAGE_WORDS = 32;
  localparam int FSPS_PTR_WORD_LSB = 1;
  localparam int FSPS_PTR_PAGE_LSB = 6;
  localparam int FSPS_ADDR_W = FSPS_PAGE_W + FSPS_WORD_W;
  localparam logic [15:0] FSPS_ERASED_WORD = 16'hFFFF;
  // ****************************************
  // Control register codes and bits
  // ****************************************
  localparam logic [7:0] FSPS_CMD_LOAD = 8'h01;
  localparam logic [7:0] FSPS_CMD_ERASE = 8'h03;
  localparam logic [7:0] FSPS_CMD_WRITE = 8'h05;
  localparam logic [7:0] FSPS_CTRL_RST = 8'h00;
  localparam int FSPS_CTRL_EN_BIT = 0;
  localparam int FSPS_CTRL_CLEAR_BIT = 4;
  localparam int FSPS_CTRL_W = 6;
  localparam logic [2:0] FSPS_ISSUE_WINDOW = 3'h4;
  // ****************************************
  // Status register bits
  // ****************************************
  localparam int FSPS_ST_BUSY = 0;
  localparam int FSPS_ST_WINDOW = 1;
  localparam int FSPS_ST_FUSE_EN = 2;
  localparam int FSPS_ST_NVM_BUSY = 3;
  localparam int FSPS_ST_BUF_USED = 4;
  // ****************************************
  // Bus map
  // ****************************************
  localparam int FSPS_DEC_W = 8;
  localparam logic [7:0] FSPS_REG_CTRL = 8'h00;
  localparam logic [7:0] FSPS_REG_STATUS = 8'h04;
  // ****************************************
  // Timing
  // ****************************************
  localparam int FSPS_CLK_PERIOD_NS = 8;
  localparam real FSPS_PROG_MIN_MS = 3.7;
  localparam real FSPS_PROG_MAX_MS = 4.5;
  localparam int FSPS_PROG_MIN_CYC = int'($ceil(FSPS_PROG_MIN_MS * 1.0e6 / FSPS_CLK_PERIOD_NS));
  localparam int FSPS_PROG_MAX_CYC = int'($floor(FSPS_PROG_MAX_MS * 1.0e6 / FSPS_CLK_PERIOD_NS));
  localparam int FSPS_TIMER_W = 20;
  typedef enum logic [1:0] {
    FSPS_IDLE = 2'b00,
    FSPS_XFER = 2'b01,
    FSPS_WAIT = 2'b10
  } fsps_state_t;
endpackage : fsps_pkg

// ### rtl/fsps_sequencer.sv
// Flash self-programming sequencer: page buffer, erase and write control.
// Assumes core-side strobes on clk, a strap pin for the enable fuse and a
// flash array that answers a read address with data in the same cycle.
//
// Behaviour
// R1 - Store ignored unless enable fuse programmed zero
// R2 - Software erases a page before writing it
// R3 - Buffer loads one word per store
// R4 - Buffer words may load in any order
// R5 - Code 03 then store within four: erase
// R6 - Processor halted for whole page erase
// R7 - Code 01 then store within four: load
// R8 - Buffer cleared after write, clear bit, reset
// R9 - Software loads each buffer address once
// R10 - Data memory write discards loaded words
// R11 - Code 05 then store within four: write
// R12 - Processor halted for whole page write
// R13 - Pointer low bits word, high bits page
// R14 - Software uses same page for erase, write
// R15 - Program read uses pointer bit zero byte
// R16 - Software preserves unchanged words around erase
// R17 - Erase and write last 3.7 to 4.5 ms
// R18 - Data memory write blocks flash commands
// R19 - Missed window clears command, does nothing
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module fsps_sequencer #(
  parameter int PROG_CYCLES = fsps_pkg::FSPS_PROG_MIN_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic hreadyout, // AHB ready out
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response
  input wire logic self_prog_enable_fuse_n, // Fuse pin, low enables
  input wire logic store_prog_mem_instr, // Store instruction strobe
  input wire logic [15:0] ptr, // Pointer register pair
  input wire logic [7:0] data_high_reg, // Word high byte
  input wire logic [7:0] data_low_reg, // Word low byte
  input wire logic lpm_req, // Program read strobe
  input wire logic nvm_write_busy, // Data memory write in progress
  input wire logic [15:0] flash_rdata, // Flash read data
  output logic [fsps_pkg::FSPS_ADDR_W-1:0] flash_addr, // Flash program address
  output logic [15:0] flash_wdata, // Flash program data
  output logic flash_wr_en, // Word transfer strobe
  output logic flash_erase, // Page erase start
  output logic flash_prog, // Page program start
  output logic [14:0] flash_rd_addr, // Flash read word address
  output logic [7:0] lpm_data, // Program read byte
  output logic lpm_valid, // Program read byte valid
  output logic cpu_halt // Processor stall
);
  import fsps_pkg::*;

  // ****************************************
  // Fuse strap synchroniser
  // ****************************************
  logic fuse_s1_r;
  logic fuse_s2_r;
  logic fuse_en;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuse_s1_r <= 1'b1;
      fuse_s2_r <= 1'b1;
    end else if (ce) begin
      fuse_s1_r <= self_prog_enable_fuse_n;
      fuse_s2_r <= fuse_s1_r;
    end
  end
  assign fuse_en = !fuse_s2_r;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic [7:0] ctrl_r;
  logic [2:0] win_cnt_r;
  fsps_state_t state_r;
  logic [FSPS_PAGE_WORDS-1:0] buf_valid_r;
  logic wr_pend_r;
  logic [FSPS_DEC_W-1:0] wr_addr_r;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic ctrl_wr;
  logic clear_req;

  assign addr_ok = hsel && htrans[1] && hready;
  always_comb begin
    status_word = '0;
    status_word[FSPS_ST_BUSY] = (state_r != FSPS_IDLE);
    status_word[FSPS_ST_WINDOW] = (win_cnt_r != 3'h0);
    status_word[FSPS_ST_FUSE_EN] = fuse_en;
    status_word[FSPS_ST_NVM_BUSY] = nvm_write_busy;
    status_word[FSPS_ST_BUF_USED] = |buf_valid_r;
    case (haddr[FSPS_DEC_W-1:0])
      FSPS_REG_CTRL: rd_mux = {24'h00_0000, ctrl_r};
      FSPS_REG_STATUS: rd_mux = status_word;
      default: rd_mux = '0;
    endcase
  end

  // Zero wait state: ready is a constant after reset, response always OKAY
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= '0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[FSPS_DEC_W-1:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Busy or data-memory write in flight: control writes dropped
  assign ctrl_wr = wr_pend_r && (wr_addr_r == FSPS_REG_CTRL) &&
                   !nvm_write_busy && (state_r == FSPS_IDLE); // R18
  assign clear_req = ctrl_wr && hwdata[FSPS_CTRL_CLEAR_BIT]; // R8

  // ****************************************
  // Command window
  // ****************************************
  logic spm_ok;
  logic load_go;
  logic erase_go;
  logic write_go;
  logic [FSPS_WORD_W-1:0] word_sel;
  logic [FSPS_PAGE_W-1:0] page_sel;

  assign word_sel = ptr[FSPS_PTR_WORD_LSB +: FSPS_WORD_W]; // R13
  assign page_sel = ptr[FSPS_PTR_PAGE_LSB +: FSPS_PAGE_W]; // R13
  assign spm_ok = store_prog_mem_instr && fuse_en && (win_cnt_r != 3'h0) &&
                  !nvm_write_busy && (state_r == FSPS_IDLE); // R1 R18
  assign load_go = spm_ok && (ctrl_r == FSPS_CMD_LOAD); // R7 R3
  assign erase_go = spm_ok && (ctrl_r == FSPS_CMD_ERASE); // R5
  assign write_go = spm_ok && (ctrl_r == FSPS_CMD_WRITE); // R11

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= FSPS_CTRL_RST;
      win_cnt_r <= 3'h0;
    end else if (ce) begin
      if (ctrl_wr) begin
        // Clear bit acts at once and is never stored
        // Top two bits are reserved and read zero
        ctrl_r <= {2'b00, hwdata[FSPS_CTRL_W-1], 1'b0, hwdata[FSPS_CTRL_CLEAR_BIT-1:0]};
        win_cnt_r <= hwdata[FSPS_CTRL_EN_BIT] ? FSPS_ISSUE_WINDOW : 3'h0;
      end else if (spm_ok || win_cnt_r == 3'h1) begin
        ctrl_r <= FSPS_CTRL_RST; // R19
        win_cnt_r <= 3'h0;
      end else if (win_cnt_r != 3'h0) begin
        win_cnt_r <= win_cnt_r - 3'h1;
      end
    end
  end

  // ****************************************
  // Temporary page buffer
  // ****************************************
  logic [15:0] buf_data_r [FSPS_PAGE_WORDS];
  logic buf_clear;
  logic prog_done;

  // Data-memory write during a load discards everything loaded so far
  assign buf_clear = clear_req || prog_done ||
                     (nvm_write_busy && |buf_valid_r && state_r == FSPS_IDLE); // R8 R10

  generate
    for (genvar i = 0; i < FSPS_PAGE_WORDS; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          buf_data_r[i] <= FSPS_ERASED_WORD; // R8
          buf_valid_r[i] <= 1'b0;
        end else if (ce) begin
          if (buf_clear) begin
            buf_data_r[i] <= FSPS_ERASED_WORD;
            buf_valid_r[i] <= 1'b0;
          end else if (load_go && word_sel == FSPS_WORD_W'(i)) begin
            // Reload without clearing only lowers bits, as flash would
            buf_data_r[i] <= buf_data_r[i] & {data_high_reg, data_low_reg}; // R4
            buf_valid_r[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Erase and write sequencer
  // ****************************************
  logic [FSPS_WORD_W-1:0] xfer_idx_r;
  logic [FSPS_TIMER_W-1:0] timer_r;
  logic [FSPS_PAGE_W-1:0] op_page_r;
  logic op_write_r;

  assign prog_done = (state_r == FSPS_WAIT) && (timer_r == '0) && op_write_r; // R8

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= FSPS_IDLE;
      xfer_idx_r <= '0;
      timer_r <= '0;
      op_page_r <= '0;
      op_write_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        FSPS_IDLE: begin
          if (erase_go || write_go) begin
            op_page_r <= page_sel; // R5 R11
            op_write_r <= write_go;
            xfer_idx_r <= '0;
            timer_r <= FSPS_TIMER_W'(PROG_CYCLES - 1); // R17
            state_r <= write_go ? FSPS_XFER : FSPS_WAIT;
          end
        end
        FSPS_XFER: begin
          xfer_idx_r <= xfer_idx_r + 1'b1;
          // Transfer time counts toward the programming time
          timer_r <= timer_r - 1'b1; // R17
          if (xfer_idx_r == FSPS_WORD_W'(FSPS_PAGE_WORDS - 1)) begin
            state_r <= FSPS_WAIT;
          end
        end
        FSPS_WAIT: begin
          if (timer_r == '0) begin
            state_r <= FSPS_IDLE;
          end else begin
            timer_r <= timer_r - 1'b1; // R17
          end
        end
        default: state_r <= FSPS_IDLE;
      endcase
    end
  end

  // ****************************************
  // Flash array and processor outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_addr <= '0;
      flash_wdata <= '0;
      flash_wr_en <= 1'b0;
      flash_erase <= 1'b0;
      flash_prog <= 1'b0;
      cpu_halt <= 1'b0;
    end else if (ce) begin
      flash_wr_en <= (state_r == FSPS_XFER);
      flash_wdata <= buf_data_r[xfer_idx_r];
      flash_addr <= (state_r == FSPS_XFER) ? {op_page_r, xfer_idx_r} :
                    {page_sel, {FSPS_WORD_W{1'b0}}};
      flash_erase <= erase_go; // R5
      flash_prog <= (state_r == FSPS_XFER) &&
                    (xfer_idx_r == FSPS_WORD_W'(FSPS_PAGE_WORDS - 1)); // R11
      // Halt rises with the accepted store and falls with the timer
      cpu_halt <= (erase_go || write_go) ? 1'b1 :
                  (state_r == FSPS_WAIT && timer_r == '0) ? 1'b0 : cpu_halt; // R6 R12
    end
  end

  // Byte-wide program read: flash answers a word in the same cycle as its address
  logic byte_sel_r;
  logic lpm_pend_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_rd_addr <= '0;
      byte_sel_r <= 1'b0;
      lpm_pend_r <= 1'b0;
      lpm_data <= '0;
      lpm_valid <= 1'b0;
    end else if (ce) begin
      lpm_pend_r <= lpm_req;
      lpm_valid <= lpm_pend_r;
      if (lpm_req) begin
        flash_rd_addr <= ptr[15:1]; // R15
        byte_sel_r <= ptr[0];
      end
      if (lpm_pend_r) begin
        lpm_data <= byte_sel_r ? flash_rdata[15:8] : flash_rdata[7:0]; // R15
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  a_fuse_gates_store: assert property ( // R1
    store_prog_mem_instr && fuse_s2_r |=> !flash_erase && (!cpu_halt || $past(cpu_halt)))
    else $error("store acted while self-programming disabled");
  a_erase_halts_cpu: assert property ( // R6
    erase_go |=> flash_erase && cpu_halt ##1 cpu_halt[*8])
    else $error("erase did not halt the processor");
  a_write_halts_cpu: assert property ( // R12
    write_go |=> (cpu_halt && state_r == FSPS_XFER) ##32 (cpu_halt && state_r == FSPS_WAIT))
    else $error("write transfer without processor halt");
  // Busy and halt share one window, so no cycle of a transfer runs unhalted
  a_busy_halts_cpu: assert property ( // R6 R12
    state_r != FSPS_IDLE |-> cpu_halt)
    else $error("sequencer busy without processor halt");
  a_erase_page_addr: assert property ( // R5 R13
    erase_go |=> flash_addr == {$past(page_sel), {FSPS_WORD_W{1'b0}}})
    else $error("erase started on wrong page");
  a_window_closes: assert property ( // R19
    $rose(win_cnt_r != 3'h0) |-> ##[1:4] (win_cnt_r == 3'h0 && ctrl_r == FSPS_CTRL_RST))
    else $error("command window outlived four cycles");
  a_load_marks_word: assert property ( // R7
    load_go && !buf_clear |=> buf_valid_r[$past(word_sel)])
    else $error("loaded word not marked in buffer");
  a_clear_empties: assert property ( // R8
    buf_clear |=> buf_valid_r == '0)
    else $error("buffer not emptied after clear");
  a_nvm_blocks_ctrl: assert property ( // R18
    nvm_write_busy && wr_pend_r |=> ctrl_r == $past(ctrl_r) || ctrl_r == FSPS_CTRL_RST)
    else $error("control written during data memory write");
  a_nvm_discards: assert property ( // R10
    nvm_write_busy && |buf_valid_r && state_r == FSPS_IDLE |=> buf_valid_r == '0)
    else $error("loaded words survived data memory write");
  a_read_address: assert property ( // R15
    lpm_req |=> flash_rd_addr == $past(ptr[15:1]) ##1 lpm_valid)
    else $error("program read address or valid wrong");
  a_write_length: assert property ( // R17
    $rose(state_r == FSPS_WAIT) && op_write_r |->
      timer_r == FSPS_TIMER_W'(PROG_CYCLES - 1 - FSPS_PAGE_WORDS))
    else $error("programming timer mis-set");
endmodule : fsps_sequencer
`default_nettype wire

// ### testbench/fsps_flash_model.sv
// Flash array model standing behind the self-programming sequencer.
// Assumes a combinational array read: data follows flash_rd_addr at once.
`timescale 1ns/1ns
`default_nettype none
module fsps_flash_model
  import fsps_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic [fsps_pkg::FSPS_ADDR_W-1:0] flash_addr, // Program address
  input wire logic [15:0] flash_wdata, // Program data
  input wire logic flash_wr_en, // Word strobe
  input wire logic flash_erase, // Page erase start
  input wire logic [14:0] flash_rd_addr, // Read address
  output logic [15:0] flash_rdata // Read data
);
  // ********
  // Array
  // ********
  logic [15:0] mem [0:32767];
  initial begin
    // Stale contents, so a missing erase shows up
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 16'h5A5A;
    end
  end
  always @(posedge clk) begin
    if (flash_erase === 1'b1) begin
      for (int i = 0; i < FSPS_PAGE_WORDS; i++) begin
        mem[{flash_addr[14:5], 5'(i)}] <= 16'hFFFF;
      end
    end
    // Cells only clear bits, as real flash does
    if (flash_wr_en === 1'b1) begin
      mem[flash_addr] <= mem[flash_addr] & flash_wdata;
    end
  end
  assign flash_rdata = mem[flash_rd_addr];
endmodule : fsps_flash_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the flash self-programming sequencer.
// Assumes the AHB-Lite slave is alone on its bus and a shortened program time.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fsps_pkg::*;
  localparam int PC = 64;
  localparam logic [31:0] T = 32'h0000_0001;
  localparam logic [31:0] F = 32'h0000_0000;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, fuse_n = 1'b0;
  logic store = 1'b0, lpm_req = 1'b0, nvm_busy = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
  logic [31:0] rd_bus;
  logic [1:0] htrans = 2'b00;
  logic [15:0] ptr = 16'h0000, frd, fwd;
  logic [7:0] dh = 8'h00, dl = 8'h00, lpm_data;
  logic [14:0] faddr, fraddr, er_addr;
  logic hreadyout, hresp, wr_en, erase, prog, lpm_valid, cpu_halt;
  int err_count = 0, checks = 0, n_wr = 0, n_prog = 0, h;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (wr_en === 1'b1) n_wr++;
    if (prog === 1'b1) n_prog++;
    if (erase === 1'b1) er_addr = faddr;
  end
  fsps_sequencer #(.PROG_CYCLES(PC)) fsps_sequencer_i (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(rd_bus), .hresp(hresp), .self_prog_enable_fuse_n(fuse_n),
    .store_prog_mem_instr(store), .ptr(ptr), .data_high_reg(dh), .data_low_reg(dl),
    .lpm_req(lpm_req), .nvm_write_busy(nvm_busy), .flash_rdata(frd), .flash_addr(faddr),
    .flash_wdata(fwd), .flash_wr_en(wr_en), .flash_erase(erase), .flash_prog(prog),
    .flash_rd_addr(fraddr), .lpm_data(lpm_data), .lpm_valid(lpm_valid), .cpu_halt(cpu_halt)
  );
  fsps_flash_model fsps_flash_model_i (
    .clk(clk), .flash_addr(faddr), .flash_wdata(fwd), .flash_wr_en(wr_en),
    .flash_erase(erase), .flash_rd_addr(fraddr), .flash_rdata(frd)
  );
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("bus wait", F, T);
      report_and_stop();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    wait_rdy();
    rd = rd_bus;
  endtask : bus
  // Window bit masked: its timing is not pinned down
  task automatic st(input string nm, input logic [31:0] exp);
    bus(1'b0, FSPS_REG_STATUS, 8'h00);
    chk(nm, rd & 32'h0000_001D, exp);
  endtask : st
  task automatic cmd(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d,
                     input int gap);
    bus(1'b1, FSPS_REG_CTRL, c);
    repeat (gap) @(posedge clk);
    store <= 1'b1;
    ptr <= p;
    {dh, dl} <= d;
    @(posedge clk);
    store <= 1'b0;
    ptr <= ~p;
    {dh, dl} <= ~d;
  endtask : cmd
  task automatic halt_len();
    h = 0;
    repeat (PC + 20) begin
      @(posedge clk);
      if (cpu_halt === 1'b1) h++;
    end
  endtask : halt_len
  task automatic lpm(input logic [15:0] p, input logic [7:0] exp);
    int n = 0;
    lpm_req <= 1'b1;
    ptr <= p;
    @(posedge clk);
    lpm_req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (lpm_valid !== 1'b1 && n < 8);
    chk("lpm valid", {31'h0, lpm_valid}, T);
    chk("lpm byte", {24'h00_0000, lpm_data}, {24'h00_0000, exp});
  endtask : lpm
  // ********
  // Sequence
  // ********
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    st("status reset", 32'h0000_0004);
    bus(1'b0, FSPS_REG_CTRL, 8'h00);
    chk("ctrl reset", rd, F);
    bus(1'b0, 8'h08, 8'h00);
    chk("unmapped", rd, F);
    cmd(FSPS_CMD_LOAD, 16'h00CA, 16'hA5C3, 0);
    cmd(FSPS_CMD_LOAD, 16'h00C4, 16'h1234, 3);
    st("buffer used", 32'h0000_0014);
    bus(1'b0, FSPS_REG_CTRL, 8'h00);
    chk("ctrl after accept", rd, F);
    cmd(FSPS_CMD_ERASE, 16'h00CF, 16'h0000, 0);
    halt_len();
    chk("erase halt", 32'(h >= PC - 1 && h <= PC), T);
    chk("erase page", {17'h0_0000, er_addr}, 32'h0000_0060);
    n_wr = 0;
    n_prog = 0;
    cmd(FSPS_CMD_WRITE, 16'h00C0, 16'hFFFF, 1);
    halt_len();
    chk("write halt", 32'(h >= PC - 1 && h <= PC), T);
    chk("word transfers", n_wr, 32'h0000_0020);
    chk("program starts", n_prog, T);
    st("buffer after write", 32'h0000_0004);
    lpm(16'h00CA, 8'hC3);
    lpm(16'h00CB, 8'hA5);
    lpm(16'h00C5, 8'h12);
    lpm(16'h00CE, 8'hFF);
    cmd(FSPS_CMD_LOAD, 16'h00C2, 16'h0F0F, 5);
    st("late store", 32'h0000_0004);
    cmd(FSPS_CMD_LOAD, 16'h00C2, 16'h0F0F, 0);
    st("loaded", 32'h0000_0014);
    bus(1'b1, FSPS_REG_CTRL, 8'h10);
    st("cleared", 32'h0000_0004);
    cmd(FSPS_CMD_LOAD, 16'h00C2, 16'h0F0F, 0);
    nvm_busy <= 1'b1;
    @(posedge clk);
    st("nvm discards", 32'h0000_000C);
    cmd(FSPS_CMD_ERASE, 16'h00C0, 16'h0000, 0);
    halt_len();
    chk("nvm blocks", h, F);
    nvm_busy <= 1'b0;
    fuse_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(FSPS_CMD_LOAD, 16'h00C2, 16'h1111, 0);
    st("fuse off", F);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
